/* logic/swrc_pkg.sv */
package swrc_pkg;
	// Register byte offsets, one aligned word each
	localparam logic [3:0] MCU_CTRL_OFS  = 4'h0;
	localparam logic [3:0] COMP_CTRL_OFS = 4'h4;
	localparam logic [3:0] STATUS_OFS    = 4'h8;
	localparam logic [3:0] CAUSE_OFS     = 4'hc;

	// Field positions
	localparam int SE_BIT      = 0;
	localparam int SM_BIT      = 1;
	localparam int CD_BIT      = 7;
	localparam int STATE_LSB   = 0;
	localparam int VARIANT_BIT = 4;
	localparam int CAUSE_POR   = 0;
	localparam int CAUSE_EXT   = 1;
	localparam int CAUSE_WDT   = 2;
	localparam int CAUSE_BOD   = 3;

	// Reset values
	localparam logic       SE_RST    = 1'b0;
	localparam logic       SM_RST    = 1'b0;
	localparam logic       CD_RST    = 1'b0;
	localparam logic [3:0] CAUSE_RST = 4'h0;

	// Timing
	localparam int CLK_MHZ           = 250;
	localparam int RST_PIN_MIN_NS    = 50;
	localparam int RST_PIN_CYC       = (RST_PIN_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int WDT_NOM_PERIOD_NS = 2700;
	localparam int WAKE_QUAL_TICKS   = 2;
	localparam int CAL_WAKE_HALT_CYC = 4;
	localparam int PC_FLAG_DELAY_CYC = 2;
	localparam int CK_6              = 6;
	localparam int CK_1K             = 1024;
	localparam int CK_16K            = 16384;
	localparam int CK_32K            = 32768;
	localparam int WDT_256           = 256;
	localparam int WDT_1K            = 1024;
	localparam int WDT_4K            = 4096;

	// Sleep and reset sequencing states
	typedef enum logic [2:0] {
		ST_RUN     = 3'b000,
		ST_IDLE    = 3'b001,
		ST_PDOWN   = 3'b010,
		ST_WAKEDLY = 3'b011,
		ST_HALT    = 3'b100,
		ST_RESET   = 3'b101,
		ST_BOOT    = 3'b110
	} swrc_state_t;

	// Classic Wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} swrc_wb_req_t;
endpackage

/* logic/swrc_sync.sv */
`timescale 1ns/10ps
module swrc_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Asynchronous inputs and their synchronised copies
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_reg;

	// Two stages; the first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_reg <= RST_VAL;
			syncOut  <= RST_VAL;
		end else begin
			meta_reg <= asyncIn;
			syncOut  <= meta_reg;
		end
	end
endmodule

/* logic/swrc_top.sv */
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module swrc_top #(
	parameter int WAKE_CK_16K = swrc_pkg::CK_16K,
	parameter int WAKE_CK_32K = swrc_pkg::CK_32K
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Wishbone slave
	input  wire swrc_pkg::swrc_wb_req_t wbReq,
	output logic                        wbAck,
	output logic [31:0]                 wbDatOut,
	// CPU core side, same clock
	input  wire logic                   sleepInstr,
	input  wire logic                   irqReq,
	input  wire logic                   compIrq,
	input  wire logic                   extAIrqEn,
	input  wire logic                   pinChgIrqEn,
	input  wire logic                   wdtEnable,
	output logic                        cpuHalt,
	output logic                        cpuRst_n,
	output logic                        mainOscEn,
	output logic                        irqAllow,
	output logic                        wakeIrqDrop,
	output logic                        pcFlagUpdate,
	output logic                        compPowerDown,
	// Pins and analog detectors, asynchronous
	input  wire logic                   resetPin_n,
	input  wire logic                   extAPin_n,
	input  wire logic                   pinChgPin,
	input  wire logic                   wdtOscClk,
	input  wire logic                   wdtExpire,
	input  wire logic                   brownOut,
	input  wire logic                   powerOn,
	// Straps and fuses, static
	input  wire logic                   calibVariant,
	input  wire logic                   bodLevelProg,
	input  wire logic [3:0]             clkSelFuses
);
	import swrc_pkg::*;

	// Synchroniser resets to idle pin levels: reset pin and ext_a high,
	// so no false wake or reset request follows the release of rst_n
	localparam logic [12:0] SYNC_RST = 13'h0003;

	swrc_state_t stateReg;
	swrc_state_t stateNext;
	logic [12:0] syncVec;
	logic        rstPinS, extAS, pcS, wdtOscS, wdtExpS, bodS, porS;
	logic        calibS, bodProgS;
	logic [3:0]  fuseS;
	logic        calib_reg, bodProg_reg;
	logic [3:0]  fuse_reg;
	logic        wdtPrev_reg, wdtExpPrev_reg, wdtTick, wdtHit;
	logic [3:0]  rstLowCnt_reg;
	logic        extRst, resetReq;
	logic        sleepEn_reg, sleepMode_reg;
	logic [3:0]  cause_reg;
	logic        wbHit, wbWrite;
	logic [31:0] readMux;
	logic        pcRef_reg, extCond, pcCond, pdCond, idleWake;
	logic [15:0] clkCnt_reg, ckLast;
	logic [12:0] wdtCnt_reg, rtTarget;
	logic        ckDone, rtDone, haltDone;
	logic [1:0]  qualCnt_reg, pcDly_reg, pcDlyNext;
	logic        qualified, serve_reg, wakeByPc_reg;

	// Wake and reset pins pass two flops before any use
	swrc_sync #(
		.WIDTH   (13),
		.RST_VAL (SYNC_RST)
	) u_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn ({clkSelFuses, bodLevelProg, calibVariant, powerOn,
			brownOut, wdtExpire, wdtOscClk, pinChgPin, extAPin_n,
			resetPin_n}),
		.syncOut (syncVec)
	);
	assign {fuseS, bodProgS, calibS, porS, bodS, wdtExpS, wdtOscS, pcS,
		extAS, rstPinS} = syncVec;

	// Straps are caught while the reset path runs, never by the reset itself
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			calib_reg   <= 1'b0;
			bodProg_reg <= 1'b0;
			fuse_reg    <= 4'h0;
		end else if (stateReg == ST_RESET) begin
			calib_reg   <= calibS;
			bodProg_reg <= bodProgS;
			fuse_reg    <= fuseS;
		end
	end

	// Edge detection on the watchdog oscillator and its expiry strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wdtPrev_reg    <= 1'b0;
			wdtExpPrev_reg <= 1'b0;
		end else begin
			wdtPrev_reg    <= wdtOscS;
			wdtExpPrev_reg <= wdtExpS;
		end
	end
	assign wdtTick = wdtOscS && !wdtPrev_reg;
	assign wdtHit  = wdtExpS && !wdtExpPrev_reg && wdtEnable;

	// Glitch filter: the pin must stay low for the full minimum width
	always_ff @(posedge clk) begin
		if (!rst_n || rstPinS) begin
			rstLowCnt_reg <= 4'h0;
		end else if (!extRst) begin
			rstLowCnt_reg <= rstLowCnt_reg + 4'h1;
		end
	end
	assign extRst   = rstLowCnt_reg == 4'(RST_PIN_CYC);
	assign resetReq = porS || extRst || wdtHit
		|| (bodS && calib_reg);

	// Start-up counts from the fuses; long counts are module parameters
	function automatic logic [15:0] ck_count(input logic [3:0] f);
		case (f)
			4'hf, 4'he, 4'hd, 4'h9: ck_count = 16'(CK_1K - 1);
			4'hc, 4'hb, 4'ha:       ck_count = 16'(WAKE_CK_16K - 1);
			4'h8:                   ck_count = 16'(WAKE_CK_32K - 1);
			default:                ck_count = 16'(CK_6 - 1);
		endcase
	endfunction

	function automatic logic [12:0] rt_count(input logic [3:0] f,
		input logic prog);
		case (f)
			4'he, 4'hb, 4'h6, 4'h3, 4'h0:
				rt_count = prog ? 13'(WDT_1K) : 13'(WDT_256);
			4'hd, 4'ha, 4'h9, 4'h8, 4'h5, 4'h2:
				rt_count = prog ? 13'(WDT_1K) : 13'(WDT_4K);
			default:
				rt_count = 13'h0000;
		endcase
	endfunction

	assign ckLast   = ck_count(fuse_reg);
	assign rtTarget = rt_count(fuse_reg, bodProg_reg);
	assign ckDone   = clkCnt_reg == ckLast;
	assign rtDone   = (rtTarget == 13'h0000) || (wdtCnt_reg == rtTarget);
	assign haltDone = clkCnt_reg == 16'(CAL_WAKE_HALT_CYC - 1);

	// Wake conditions; pin change is judged against the level at entry
	assign extCond  = extAIrqEn && !extAS;
	assign pcCond   = pinChgIrqEn && (pcS != pcRef_reg);
	assign pdCond   = extCond || pcCond;
	assign idleWake = irqReq || (compIrq && !compPowerDown)
		|| pdCond;

	// Next state; every reset source wins over sleep handling
	always_comb begin
		stateNext = stateReg;
		if (resetReq) begin
			stateNext = ST_RESET;
		end else begin
			case (stateReg)
				ST_RUN: begin
					if (sleepInstr && sleepEn_reg) begin
						stateNext = sleepMode_reg ? ST_PDOWN : ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (idleWake) begin
						stateNext = calib_reg ? ST_HALT : ST_RUN;
					end
				end
				ST_PDOWN: begin
					if (pdCond) begin
						stateNext = ST_WAKEDLY;
					end
				end
				ST_WAKEDLY: begin
					if (!calib_reg && !pdCond) begin
						stateNext = ST_PDOWN;
					end else if (ckDone) begin
						stateNext = calib_reg ? ST_HALT : ST_RUN;
					end
				end
				ST_HALT: begin
					if (haltDone) begin
						stateNext = ST_RUN;
					end
				end
				ST_RESET: begin
					if (rtDone) begin
						stateNext = ST_BOOT;
					end
				end
				ST_BOOT: begin
					if (ckDone) begin
						stateNext = ST_RUN;
					end
				end
				default: begin
					stateNext = ST_RESET;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stateReg <= ST_RESET;
		end else begin
			stateReg <= stateNext;
		end
	end

	// Cycle counter restarts on every state change
	always_ff @(posedge clk) begin
		if (!rst_n || stateNext != stateReg) begin
			clkCnt_reg <= 16'h0000;
		end else if (clkCnt_reg != 16'hffff) begin
			clkCnt_reg <= clkCnt_reg + 16'h0001;
		end
	end

	// Real-time part counts watchdog ticks after the source releases
	always_ff @(posedge clk) begin
		if (!rst_n || resetReq || stateReg != ST_RESET) begin
			wdtCnt_reg <= 13'h0000;
		end else if (wdtTick && !rtDone) begin
			wdtCnt_reg <= wdtCnt_reg + 13'h0001;
		end
	end

	// Qualification needs the level held over consecutive ticks
	always_ff @(posedge clk) begin
		if (!rst_n || stateReg != ST_WAKEDLY) begin
			qualCnt_reg <= 2'h0;
		end else if (!qualified && !pdCond) begin
			qualCnt_reg <= 2'h0;
		end else if (!qualified && wdtTick) begin
			qualCnt_reg <= qualCnt_reg + 2'h1;
		end
	end
	assign qualified = qualCnt_reg == 2'(WAKE_QUAL_TICKS);

	// Wake bookkeeping: reference level, cause and whether to serve
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pcRef_reg    <= 1'b0;
			wakeByPc_reg <= 1'b0;
			serve_reg    <= 1'b0;
		end else begin
			if (stateReg == ST_RUN) begin
				pcRef_reg <= pcS;
			end
			if (stateReg == ST_PDOWN && pdCond) begin
				wakeByPc_reg <= pcCond && !extCond;
			end else if (stateReg == ST_IDLE) begin
				wakeByPc_reg <= 1'b0;
			end
			if (stateReg == ST_IDLE) begin
				serve_reg <= 1'b1;
			end else if (stateReg == ST_WAKEDLY) begin
				serve_reg <= qualified || pdCond;
			end
		end
	end

	// Simple variant lets two cycles run before the pin-change flag
	always_comb begin
		pcDlyNext = 2'h0;
		if (stateReg == ST_WAKEDLY && stateNext == ST_RUN && wakeByPc_reg) begin
			pcDlyNext = 2'(PC_FLAG_DELAY_CYC);
		end else if (pcDly_reg != 2'h0 && stateNext == ST_RUN) begin
			pcDlyNext = pcDly_reg - 2'h1;
		end
	end

	// CPU controls, all registered from the next state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pcDly_reg    <= 2'h0;
			cpuHalt      <= 1'b1;
			cpuRst_n     <= 1'b0;
			mainOscEn    <= 1'b1;
			irqAllow     <= 1'b0;
			wakeIrqDrop  <= 1'b0;
			pcFlagUpdate <= 1'b0;
		end else begin
			pcDly_reg    <= pcDlyNext;
			cpuHalt      <= stateNext != ST_RUN;
			cpuRst_n     <= stateNext != ST_RESET
				&& stateNext != ST_BOOT;
			mainOscEn    <= stateNext != ST_PDOWN;
			irqAllow     <= stateNext == ST_RUN && pcDlyNext == 2'h0;
			wakeIrqDrop  <= stateReg == ST_HALT && stateNext == ST_RUN
				&& !serve_reg;
			pcFlagUpdate <= (pcDly_reg == 2'h1 && pcDlyNext == 2'h0)
				|| (stateReg == ST_HALT && stateNext == ST_RUN
				&& serve_reg && wakeByPc_reg);
		end
	end

	// Wishbone: ack one cycle after the strobe, write on the ack edge
	assign wbHit   = wbReq.cyc && wbReq.stb;
	assign wbWrite = wbHit && wbReq.we && wbAck && wbReq.sel[0];

	always_comb begin
		readMux = 32'h00000000;
		case (wbReq.adr)
			MCU_CTRL_OFS: begin
				readMux[SE_BIT] = sleepEn_reg;
				readMux[SM_BIT] = sleepMode_reg;
			end
			COMP_CTRL_OFS: readMux[CD_BIT] = compPowerDown;
			STATUS_OFS: begin
				readMux[STATE_LSB +: 3] = stateReg;
				readMux[VARIANT_BIT]    = calib_reg;
			end
			CAUSE_OFS:     readMux[3:0] = cause_reg;
			default:       readMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wbAck    <= 1'b0;
			wbDatOut <= 32'h00000000;
		end else begin
			wbAck <= wbHit && !wbAck;
			if (wbHit && !wbAck) begin
				wbDatOut <= readMux;
			end
		end
	end

	// Control bits return to initial values on any reset, not on sleep
	always_ff @(posedge clk) begin
		if (!rst_n || stateReg == ST_RESET) begin
			sleepEn_reg   <= SE_RST;
			sleepMode_reg <= SM_RST;
			compPowerDown <= CD_RST;
		end else if (wbWrite && wbReq.adr == MCU_CTRL_OFS) begin
			sleepEn_reg   <= wbReq.dat[SE_BIT];
			sleepMode_reg <= wbReq.dat[SM_BIT];
		end else if (wbWrite && wbReq.adr == COMP_CTRL_OFS) begin
			compPowerDown <= wbReq.dat[CD_BIT];
		end
	end

	// Reset cause survives internal resets; set wins over write-one clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cause_reg <= CAUSE_RST;
		end else begin
			cause_reg <= (cause_reg & ~((wbWrite && wbReq.adr == CAUSE_OFS)
				? wbReq.dat[3:0] : 4'h0))
				| {bodS && calib_reg, wdtHit, extRst, porS};
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_sleep_gate;
		stateReg == ST_RUN && sleepInstr && !sleepEn_reg && !resetReq
			|=> stateReg == ST_RUN && !cpuHalt;
	endproperty
	a_sleep_gate: assert property (p_sleep_gate)
		else $error("sleep entered without sleep_enable");

	property p_mode_pd;
		stateReg == ST_RUN && sleepInstr && sleepEn_reg && sleepMode_reg
			&& !resetReq |=> stateReg == ST_PDOWN && !mainOscEn;
	endproperty
	a_mode_pd: assert property (p_mode_pd)
		else $error("mode select one did not give power-down");

	property p_mode_idle;
		stateReg == ST_RUN && sleepInstr && sleepEn_reg && !sleepMode_reg
			&& !resetReq |=> stateReg == ST_IDLE && mainOscEn && cpuHalt;
	endproperty
	a_mode_idle: assert property (p_mode_idle)
		else $error("mode select zero did not give idle");

	property p_pd_osc;
		stateReg == ST_PDOWN |-> !mainOscEn && cpuHalt;
	endproperty
	a_pd_osc: assert property (p_pd_osc)
		else $error("oscillator running in power-down");

	property p_cal_halt;
		stateReg == ST_IDLE && stateNext == ST_HALT
			|=> (cpuHalt && !irqAllow) [*4];
	endproperty
	a_cal_halt: assert property (p_cal_halt)
		else $error("halt after wake shorter than four cycles");

	property p_simple_idle;
		stateReg == ST_IDLE && idleWake && !calib_reg && !resetReq
			|=> !cpuHalt && irqAllow;
	endproperty
	a_simple_idle: assert property (p_simple_idle)
		else $error("idle wake not immediate");

	property p_reset_wake;
		resetReq |=> stateReg == ST_RESET ##1 !cpuRst_n;
	endproperty
	a_reset_wake: assert property (p_reset_wake)
		else $error("reset did not force the reset path");

	property p_pin_filter;
		!rstPinS [*8] ##1 !rstPinS [*6] |=> !cpuRst_n;
	endproperty
	a_pin_filter: assert property (p_pin_filter)
		else $error("long low on reset pin ignored");

	property p_pin_short;
		$rose(!rstPinS) ##0 (stateReg == ST_RUN && !porS) ##1 rstPinS
			|-> !extRst;
	endproperty
	a_pin_short: assert property (p_pin_short)
		else $error("short reset pulse accepted");

	property p_comp_off;
		stateReg == ST_IDLE && compPowerDown && compIrq && !irqReq
			&& !pdCond && !resetReq |=> stateReg == ST_IDLE;
	endproperty
	a_comp_off: assert property (p_comp_off)
		else $error("disabled comparator woke idle");

	property p_pc_delay;
		stateReg == ST_WAKEDLY && stateNext == ST_RUN && wakeByPc_reg
			&& !resetReq |=> !irqAllow ##1 !irqAllow && !pcFlagUpdate;
	endproperty
	a_pc_delay: assert property (p_pc_delay)
		else $error("pin-change flag not delayed two cycles");
endmodule

/* dv/swrc_far_model.sv */
`timescale 1ns/10ps
module swrc_far_model #(
	parameter int WDT_HALF_NS = 27
) (
	// Core clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Commands from the bench
	input  wire logic       wakeGo,
	input  wire logic [7:0] holdCyc,
	// Pins towards the block
	output logic            extAPin_n,
	output logic            wdtOscClk
);
	logic [7:0] holdReg;

	// Watchdog oscillator runs free, phase unrelated to clk
	initial begin
		wdtOscClk = 1'b0;
		#3;
		forever #(WDT_HALF_NS) wdtOscClk = ~wdtOscClk;
	end

	// Holds ext_a low for the commanded count; a short count breaks the hold
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			holdReg <= 8'h00;
		end else if (wakeGo) begin
			holdReg <= holdCyc;
		end else if (holdReg != 8'h00) begin
			holdReg <= holdReg - 8'h01;
		end
	end

	// Pull-up takes the pin high once released
	assign extAPin_n = (holdReg == 8'h00);
endmodule

/* dv/swrc_top_test.sv */
`timescale 1ns/10ps
module swrc_top_test;
	import swrc_pkg::*;
	logic         clk = 1'b0, rst_n = 1'b0, sleepInstr = 1'b0;
	logic         irqReq = 1'b0, compIrq = 1'b0, extAIrqEn = 1'b1;
	logic         pinChgIrqEn = 1'b0, wdtEnable = 1'b1, resetPin_n = 1'b1;
	logic         pinChgPin = 1'b0, wdtExpire = 1'b0, brownOut = 1'b0;
	logic         powerOn = 1'b0, calibVariant = 1'b0, bodLevelProg = 1'b0;
	logic         wakeGo = 1'b0;
	logic [3:0]   clkSelFuses = 4'h7;
	logic [7:0]   holdCyc = 8'h00;
	swrc_wb_req_t wbReq = '0;
	logic         wbAck, cpuHalt, cpuRst_n, mainOscEn, irqAllow;
	logic         wakeIrqDrop, pcFlagUpdate, compPowerDown;
	logic         extAPin_n, wdtOscClk;
	logic [31:0]  wbDatOut, q;
	logic [2:0]   obs;
	int           fail_count = 0, n_compared = 0;

	// Small wake counts keep the run short
	swrc_top #(.WAKE_CK_16K(40), .WAKE_CK_32K(60)) swrc_top_inst (
		.clk, .rst_n, .wbReq, .wbAck, .wbDatOut, .sleepInstr, .irqReq,
		.compIrq, .extAIrqEn, .pinChgIrqEn, .wdtEnable, .cpuHalt,
		.cpuRst_n, .mainOscEn, .irqAllow, .wakeIrqDrop, .pcFlagUpdate,
		.compPowerDown, .resetPin_n, .extAPin_n, .pinChgPin, .wdtOscClk,
		.wdtExpire, .brownOut, .powerOn, .calibVariant, .bodLevelProg,
		.clkSelFuses
	);
	swrc_far_model swrc_far_model_inst (
		.clk, .rst_n, .wakeGo, .holdCyc, .extAPin_n, .wdtOscClk
	);

	// Clock and the outputs that waits index into
	always #2 clk = ~clk;
	assign obs = {cpuRst_n, mainOscEn, cpuHalt};

	task automatic chk(input string s, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", s, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Bounded wait for a level, returns the edges spent
	task automatic wait_for(input int w, input logic v, input string s,
			output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (obs[w] !== v && n < 3000);
		chk(s, obs[w], v);
	endtask

	// One classic cycle; holds everything until ack is sampled
	task automatic wb(input logic w, input logic [3:0] a,
			input logic [31:0] d);
		int n;
		@(posedge clk);
		wbReq <= '{1'b1, 1'b1, w, a, 4'hf, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		q = wbDatOut;
		wbReq <= '0;
		if (n >= 50) chk("wb ack", 32'h0, 32'h1);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e,
			input string s);
		wb(1'b0, a, 32'h0);
		chk(s, q, e);
	endtask

	// Straps are only captured in reset, so each variant needs one
	task automatic do_reset(input logic cv, input logic [3:0] fz);
		int n;
		@(posedge clk);
		calibVariant <= cv;
		clkSelFuses  <= fz;
		rst_n        <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		wait_for(0, 1'b0, "boot", n);
	endtask

	task automatic enter_sleep(input logic m);
		wb(1'b1, MCU_CTRL_OFS, {30'h0, m, 1'b1});
		@(posedge clk);
		sleepInstr <= 1'b1;
		@(posedge clk);
		sleepInstr <= 1'b0;
		#1;
		chk("halt", cpuHalt, 1'b1);
		chk("osc", mainOscEn, !m);
	endtask

	task automatic t_regs;
		rd(MCU_CTRL_OFS, 32'h0, "ctrl rst");
		rd(COMP_CTRL_OFS, 32'h0, "comp rst");
		rd(CAUSE_OFS, 32'h0, "cause rst");
		rd(STATUS_OFS, 32'h0, "status run");
		rd(4'h2, 32'h0, "unmapped");
		wb(1'b1, COMP_CTRL_OFS, 32'h80);
		#1;
		chk("comp off", compPowerDown, 1'b1);
		rd(COMP_CTRL_OFS, 32'h80, "comp rw");
		wb(1'b1, COMP_CTRL_OFS, 32'h0);
		// Sleep request with sleep_enable clear must do nothing
		wb(1'b1, MCU_CTRL_OFS, 32'h2);
		@(posedge clk);
		sleepInstr <= 1'b1;
		@(posedge clk);
		sleepInstr <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("no sleep", {cpuHalt, mainOscEn}, 2'b01);
		$display("test regs done");
	endtask

	task automatic t_idle(input int expN);
		int n;
		wb(1'b1, COMP_CTRL_OFS, 32'h80);
		enter_sleep(1'b0);
		rd(STATUS_OFS, {27'h0, calibVariant, 1'b0, 3'h1}, "st idle");
		@(posedge clk);
		compIrq <= 1'b1;
		repeat (8) @(posedge clk);
		#1;
		chk("comp wake", cpuHalt, 1'b1);
		@(posedge clk);
		compIrq <= 1'b0;
		irqReq  <= 1'b1;
		wait_for(0, 1'b0, "idle wake", n);
		chk("wake lat", n, expN);
		chk("irq ok", irqAllow, 1'b1);
		@(posedge clk);
		irqReq <= 1'b0;
		rd(MCU_CTRL_OFS, 32'h1, "ctrl kept");
		rd(COMP_CTRL_OFS, 32'h80, "comp kept");
		wb(1'b1, COMP_CTRL_OFS, 32'h0);
		$display("test idle done");
	endtask

	task automatic t_pd_ext(input int expN);
		int n;
		enter_sleep(1'b1);
		@(posedge clk);
		wakeGo  <= 1'b1;
		holdCyc <= 8'd200;
		@(posedge clk);
		wakeGo <= 1'b0;
		wait_for(1, 1'b1, "osc up", n);
		wait_for(0, 1'b0, "pd wake", n);
		chk("pd delay", n, expN);
		chk("irq ok", irqAllow, 1'b1);
		chk("no drop", wakeIrqDrop, 1'b0);
		repeat (210) @(posedge clk);
		$display("test power-down done");
	endtask

	task automatic t_pc;
		int n;
		@(posedge clk);
		pinChgIrqEn <= 1'b1;
		enter_sleep(1'b1);
		@(posedge clk);
		pinChgPin <= ~pinChgPin;
		wait_for(0, 1'b0, "pc wake", n);
		chk("pc irq0", {irqAllow, pcFlagUpdate}, 2'b00);
		@(posedge clk);
		#1;
		chk("pc irq1", {irqAllow, pcFlagUpdate}, 2'b00);
		@(posedge clk);
		#1;
		chk("pc irq2", {irqAllow, pcFlagUpdate}, 2'b11);
		@(posedge clk);
		pinChgIrqEn <= 1'b0;
		$display("test pin change done");
	endtask

	// Wake level dropped before the wake delay ends
	task automatic t_pd_short(input logic cv);
		int n;
		enter_sleep(1'b1);
		@(posedge clk);
		wakeGo  <= 1'b1;
		holdCyc <= cv ? 8'd5 : 8'd4;
		@(posedge clk);
		wakeGo <= 1'b0;
		if (cv) begin
			wait_for(0, 1'b0, "drop wake", n);
			chk("irq drop", wakeIrqDrop, 1'b1);
		end else begin
			repeat (40) @(posedge clk);
			#1;
			chk("no wake", {cpuHalt, mainOscEn}, 2'b10);
		end
		$display("test short wake done");
	endtask

	// Each reset source hits while powered down
	task automatic src_reset(input int k);
		int n;
		enter_sleep(1'b1);
		@(posedge clk);
		case (k)
			0: powerOn <= 1'b1;
			1: resetPin_n <= 1'b0;
			2: wdtExpire <= 1'b1;
			default: brownOut <= 1'b1;
		endcase
		wait_for(2, 1'b0, "rst in", n);
		repeat (20) @(posedge clk);
		powerOn    <= 1'b0;
		resetPin_n <= 1'b1;
		wdtExpire  <= 1'b0;
		brownOut   <= 1'b0;
		wait_for(0, 1'b0, "rst out", n);
		chk("cpu run", cpuRst_n, 1'b1);
		rd(CAUSE_OFS, 32'h1 << k, "cause");
		rd(MCU_CTRL_OFS, 32'h0, "ctrl clr");
		wb(1'b1, CAUSE_OFS, 32'hf);
		rd(CAUSE_OFS, 32'h0, "cause clr");
		$display("test reset source done");
	endtask

	// Main sequence: simple variant, long fuse, then calibrated variant
	initial begin
		do_reset(1'b0, 4'h7);
		t_regs();
		t_idle(1);
		t_pd_ext(CK_6);
		t_pc();
		t_pd_short(1'b0);
		src_reset(0);
		src_reset(1);
		src_reset(2);
		do_reset(1'b0, 4'hc);
		t_pd_ext(40);
		do_reset(1'b1, 4'h7);
		t_idle(1 + CAL_WAKE_HALT_CYC);
		t_pd_ext(CK_6 + CAL_WAKE_HALT_CYC);
		t_pd_short(1'b1);
		src_reset(3);
		wrap_up();
	end

	// Cuts a hang short well past the expected run length
	initial begin
		#200000;
		fail_count++;
		wrap_up();
	end
endmodule
